// >>> rtl/cfc_pkg.sv
package cfc_pkg;
   // ----------------------------------------------------------------
   // Channel register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RS_DEC = 8'h90;
   localparam logic [7:0] ADDR_RS_INTERP = 8'h91;
   localparam logic [7:0] ADDR_RS_SCALE = 8'h92;
   localparam logic [7:0] ADDR_RSVD_A = 8'h93;
   localparam logic [7:0] ADDR_FO_DEC = 8'h94;
   localparam logic [7:0] ADDR_FO_SCALE = 8'h95;
   localparam logic [7:0] ADDR_RSVD_B = 8'h96;
   localparam logic [7:0] ADDR_CF_DEC = 8'ha0;
   localparam logic [7:0] ADDR_CF_PHASE = 8'ha1;
   localparam logic [7:0] ADDR_CF_TAPS = 8'ha2;
   localparam logic [7:0] ADDR_CF_PTR = 8'ha3;
   localparam logic [7:0] ADDR_CF_CTRL = 8'ha4;
   localparam logic [7:0] ADDR_ST_I = 8'ha5;
   localparam logic [7:0] ADDR_ST_Q = 8'ha6;
   localparam logic [7:0] ADDR_COEF_TOP = 8'h7f;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int RS_EXP_INV_BIT = 11;
   localparam int RS_EXP_WT_BIT = 10;
   localparam int RS_QUIET_LSB = 5;
   localparam int RS_LOUD_LSB = 0;
   localparam int CF_BYPASS_BIT = 10;
   localparam int CF_INSEL_BIT = 9;
   localparam int CF_BANK_BIT = 8;
   localparam int CF_COMMON_BIT = 7;
   localparam int CF_FORCE_BIT = 6;
   localparam int CF_FMT_LSB = 4;
   localparam int CF_SCALE_LSB = 0;

   // ----------------------------------------------------------------
   // Output formats and reset values
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_FIXED = 2'h0,
      FMT_FLOAT8 = 2'h1,
      FMT_FLOAT12 = 2'h2
   } cfc_fmt_t;
   localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : cfc_pkg

// >>> rtl/cfc_channel_cfg.sv
// Functional notes
// [RULE1] Resampler decimation is written value plus one, 1 to 4096.
// [RULE2] Host keeps resampler decimation above interpolation with a usable scale.
// [RULE3] Resampler interpolation is written value plus one, 1 to 512.
// [RULE4] Scale bit 11 inverts input exponent polarity.
// [RULE5] Scale bit 10 picks 6.02 dB or 12.02 dB per exponent step.
// [RULE6] Two 5-bit scales, bits 9-5 and 4-0, chosen by level indicator pin.
// [RULE7] Host writes zeros to reserved locations 0x93 and 0x96.
// [RULE8] Fifth-order decimation is 8-bit value plus one.
// [RULE9] Coefficient filter decimation is 8-bit value plus one, up to 256.
// [RULE10] Phase select applies at each filter start and survives sync.
// [RULE11] Tap count is written value plus one.
// [RULE12] Coefficient pointer is shadowed, reloaded only at filter start.
// [RULE13] Bypass bit routes fifth-order output to self-test registers.
// [RULE14] Input select bit takes a partner channel's fifth-order output.
// [RULE15] Bank bit picks the 128-word coefficient half for host writes.
// [RULE16] Common exponent bit shares one exponent from the larger magnitude.
// [RULE17] Force bit applies output scale in float modes; mantissas saturate.
// [RULE18] Bits 5-4 pick 12+4, 8+4 or fixed point format.
// [RULE19] Gain-loop routed data is always fixed point.
// [RULE20] Bits 3-0 give output scale for fixed point or forced scale.
// [RULE21] Mapped self-test registers show 16 bits of current output.
// [RULE22] Unmapped, self-test registers accumulate a signature.
`timescale 1ns/1ns
`default_nettype none
module cfc_channel_cfg #(
   parameter int CHANNEL = 0,
   parameter int DW = 24
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic COEF_WE,
   output logic [7:0] COEF_ADDR,
   output logic [15:0] COEF_WDATA,
   input wire logic LEVEL_IND,
   output logic EXP_INVERT,
   output logic EXP_WEIGHT_HI,
   output logic [4:0] RS_SCALE,
   output logic [12:0] RS_DECIMATION,
   output logic [9:0] RS_INTERPOLATION,
   output logic [8:0] FO_DECIMATION,
   output logic [4:0] FO_SCALE,
   output logic [8:0] CF_DECIMATION,
   output logic [8:0] CF_TAP_COUNT,
   input wire logic FILT_START,
   output logic [7:0] CF_PHASE_SEL,
   output logic [7:0] CF_POINTER,
   input wire logic [8*DW-1:0] CIC_I_ALL,
   input wire logic [8*DW-1:0] CIC_Q_ALL,
   input wire logic [7:0] CIC_VALID_ALL,
   output logic [DW-1:0] CF_IN_I,
   output logic [DW-1:0] CF_IN_Q,
   output logic CF_IN_VALID,
   input wire logic [DW-1:0] FILT_I,
   input wire logic [DW-1:0] FILT_Q,
   input wire logic FILT_VALID,
   input wire logic AGC_ROUTE,
   input wire logic MAP_TO_REGS,
   output logic [15:0] OUT_I,
   output logic [15:0] OUT_Q,
   output logic OUT_VALID
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Redundant sign bits, capped at 15: the normalising left shift
   function automatic logic [3:0] norm_of(input logic [DW-1:0] x);
      logic [4:0] n;
      logic run;
      n = 5'h00;
      run = 1'b1;
      for (int i = DW - 2; i >= 0; i--)
      begin
         if (run && x[i] == x[DW-1] && n != 5'h0f)
            n = n + 5'h01;
         else
            run = 1'b0;
      end
      return n[3:0];
   endfunction : norm_of

   // Left shift with saturation rather than wrap
   function automatic logic [DW-1:0] shl_sat(input logic [DW-1:0] x, input logic [3:0] e);
      logic [DW+15:0] w;
      w = {{16{x[DW-1]}}, x} << e;
      if (w[DW+15:DW-1] != {(17){x[DW-1]}})
         return x[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
      return w[DW-1:0];
   endfunction : shl_sat

   // Partner channel for the cross-connect
   function automatic int partner_of(input int ch);
      return (ch & 4) | (((ch & 3) == 1) ? 0 : 1);
   endfunction : partner_of

   localparam int PARTNER = partner_of(CHANNEL);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [11:0] rs_dec_q;
   logic [8:0] rs_interp_q;
   logic [11:0] rs_scale_q;
   logic [7:0] fo_dec_q;
   logic [4:0] fo_scale_q;
   logic [7:0] cf_dec_q;
   logic [7:0] cf_phase_q;
   logic [7:0] cf_taps_q;
   logic [7:0] cf_ptr_q;
   logic [10:0] cf_ctrl_q;
   logic [15:0] st_i_q;
   logic [15:0] st_q_q;

   // Write decode; reserved locations take nothing and read zero [RULE7]
   wire wr_coef = WR && ADDR <= cfc_pkg::ADDR_COEF_TOP;
   wire [7:0] coef_addr_d = {cf_ctrl_q[cfc_pkg::CF_BANK_BIT], ADDR[6:0]}; // [RULE15]

   // Control writes; all configuration clears to zero
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rs_dec_q <= cfc_pkg::REG_RESET[11:0];
         rs_interp_q <= cfc_pkg::REG_RESET[8:0];
         rs_scale_q <= cfc_pkg::REG_RESET[11:0];
         fo_dec_q <= cfc_pkg::REG_RESET[7:0];
         fo_scale_q <= cfc_pkg::REG_RESET[4:0];
         cf_dec_q <= cfc_pkg::REG_RESET[7:0];
         cf_phase_q <= cfc_pkg::REG_RESET[7:0];
         cf_taps_q <= cfc_pkg::REG_RESET[7:0];
         cf_ptr_q <= cfc_pkg::REG_RESET[7:0];
         cf_ctrl_q <= cfc_pkg::REG_RESET[10:0];
      end
      else if (WR)
      begin
         unique case (ADDR)
            cfc_pkg::ADDR_RS_DEC: rs_dec_q <= WDATA[11:0];
            cfc_pkg::ADDR_RS_INTERP: rs_interp_q <= WDATA[8:0];
            cfc_pkg::ADDR_RS_SCALE: rs_scale_q <= WDATA[11:0];
            cfc_pkg::ADDR_FO_DEC: fo_dec_q <= WDATA[7:0];
            cfc_pkg::ADDR_FO_SCALE: fo_scale_q <= WDATA[4:0];
            cfc_pkg::ADDR_CF_DEC: cf_dec_q <= WDATA[7:0];
            cfc_pkg::ADDR_CF_PHASE: cf_phase_q <= WDATA[7:0];
            cfc_pkg::ADDR_CF_TAPS: cf_taps_q <= WDATA[7:0];
            cfc_pkg::ADDR_CF_PTR: cf_ptr_q <= WDATA[7:0];
            cfc_pkg::ADDR_CF_CTRL: cf_ctrl_q <= WDATA[10:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped and reserved answer zero
   logic [15:0] rd_mux;
   always_comb
   begin
      unique case (ADDR)
         cfc_pkg::ADDR_RS_DEC: rd_mux = {4'h0, rs_dec_q};
         cfc_pkg::ADDR_RS_INTERP: rd_mux = {7'h00, rs_interp_q};
         cfc_pkg::ADDR_RS_SCALE: rd_mux = {4'h0, rs_scale_q};
         cfc_pkg::ADDR_FO_DEC: rd_mux = {8'h00, fo_dec_q};
         cfc_pkg::ADDR_FO_SCALE: rd_mux = {11'h000, fo_scale_q};
         cfc_pkg::ADDR_CF_DEC: rd_mux = {8'h00, cf_dec_q};
         cfc_pkg::ADDR_CF_PHASE: rd_mux = {8'h00, cf_phase_q};
         cfc_pkg::ADDR_CF_TAPS: rd_mux = {8'h00, cf_taps_q};
         cfc_pkg::ADDR_CF_PTR: rd_mux = {8'h00, cf_ptr_q};
         cfc_pkg::ADDR_CF_CTRL: rd_mux = {5'h00, cf_ctrl_q};
         cfc_pkg::ADDR_ST_I: rd_mux = st_i_q;
         cfc_pkg::ADDR_ST_Q: rd_mux = st_q_q;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Read data and coefficient write strobe, both registered
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         RDATA <= 16'h0000;
         COEF_WE <= 1'b0;
         COEF_ADDR <= 8'h00;
         COEF_WDATA <= 16'h0000;
      end
      else
      begin
         if (RD)
            RDATA <= rd_mux;
         COEF_WE <= wr_coef;
         if (wr_coef)
         begin
            COEF_ADDR <= coef_addr_d; // [RULE15]
            COEF_WDATA <= WDATA;
         end
      end
   end

   // ----------------------------------------------------------------
   // Filter settings
   // ----------------------------------------------------------------
   // Scale chosen by the level pin; the pin is taken as synchronous
   wire [4:0] rs_scale_d = LEVEL_IND ? rs_scale_q[cfc_pkg::RS_QUIET_LSB +: 5]
                                     : rs_scale_q[cfc_pkg::RS_LOUD_LSB +: 5]; // [RULE6]

   // Factors are presented already incremented so no stage adds one
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         RS_DECIMATION <= 13'h0001;
         RS_INTERPOLATION <= 10'h001;
         FO_DECIMATION <= 9'h001;
         CF_DECIMATION <= 9'h001;
         CF_TAP_COUNT <= 9'h001;
         RS_SCALE <= 5'h00;
         EXP_INVERT <= 1'b0;
         EXP_WEIGHT_HI <= 1'b0;
         FO_SCALE <= 5'h00;
      end
      else
      begin
         RS_DECIMATION <= {1'b0, rs_dec_q} + 13'h0001; // [RULE1]
         RS_INTERPOLATION <= {1'b0, rs_interp_q} + 10'h001; // [RULE3]
         FO_DECIMATION <= {1'b0, fo_dec_q} + 9'h001; // [RULE8]
         CF_DECIMATION <= {1'b0, cf_dec_q} + 9'h001; // [RULE9]
         CF_TAP_COUNT <= {1'b0, cf_taps_q} + 9'h001; // [RULE11]
         RS_SCALE <= rs_scale_d; // [RULE6]
         EXP_INVERT <= rs_scale_q[cfc_pkg::RS_EXP_INV_BIT]; // [RULE4]
         EXP_WEIGHT_HI <= rs_scale_q[cfc_pkg::RS_EXP_WT_BIT]; // [RULE5]
         FO_SCALE <= fo_scale_q;
      end
   end

   // Shadows load only at a filter start so mid-filter writes are safe;
   // reset is the sole clear, a channel sync leaves them alone
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         CF_PHASE_SEL <= 8'h00;
         CF_POINTER <= 8'h00;
      end
      else if (FILT_START)
      begin
         CF_PHASE_SEL <= cf_phase_q; // [RULE10]
         CF_POINTER <= cf_ptr_q; // [RULE12]
      end
   end

   // ----------------------------------------------------------------
   // Coefficient filter input cross-connect
   // ----------------------------------------------------------------
   wire in_other = cf_ctrl_q[cfc_pkg::CF_INSEL_BIT];
   wire [DW-1:0] own_i = CIC_I_ALL[CHANNEL*DW +: DW];
   wire [DW-1:0] own_q = CIC_Q_ALL[CHANNEL*DW +: DW];
   wire own_v = CIC_VALID_ALL[CHANNEL];
   wire [DW-1:0] sel_i = in_other ? CIC_I_ALL[PARTNER*DW +: DW] : own_i; // [RULE14]
   wire [DW-1:0] sel_q = in_other ? CIC_Q_ALL[PARTNER*DW +: DW] : own_q; // [RULE14]
   wire sel_v = in_other ? CIC_VALID_ALL[PARTNER] : own_v; // [RULE14]
   wire bypass = cf_ctrl_q[cfc_pkg::CF_BYPASS_BIT];

   // Feed stalls while bypassed: the filter is out of the path
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         CF_IN_I <= '0;
         CF_IN_Q <= '0;
         CF_IN_VALID <= 1'b0;
      end
      else
      begin
         CF_IN_I <= sel_i;
         CF_IN_Q <= sel_q;
         CF_IN_VALID <= sel_v && !bypass; // [RULE13]
      end
   end

   // ----------------------------------------------------------------
   // Output formatter
   // ----------------------------------------------------------------
   wire [1:0] fmt_bits = cf_ctrl_q[cfc_pkg::CF_FMT_LSB +: 2];
   wire [3:0] out_scale = cf_ctrl_q[cfc_pkg::CF_SCALE_LSB +: 4]; // [RULE20]
   wire force_scale = cf_ctrl_q[cfc_pkg::CF_FORCE_BIT];
   wire common_exp = cf_ctrl_q[cfc_pkg::CF_COMMON_BIT];
   // Gain-loop routing overrides the chosen format
   wire is_fixed = AGC_ROUTE || fmt_bits == cfc_pkg::FMT_FIXED; // [RULE18] [RULE19]
   wire is_f12 = fmt_bits[1]; // [RULE18]
   wire [3:0] norm_i = norm_of(FILT_I);
   wire [3:0] norm_q = norm_of(FILT_Q);
   // Fewer redundant sign bits means the larger magnitude
   wire [3:0] norm_c = (norm_i < norm_q) ? norm_i : norm_q; // [RULE16]
   wire [3:0] exp_i = force_scale ? out_scale : (common_exp ? norm_c : norm_i); // [RULE16] [RULE17]
   wire [3:0] exp_q = force_scale ? out_scale : (common_exp ? norm_c : norm_q); // [RULE16] [RULE17]
   wire [DW-1:0] fx_i = shl_sat(FILT_I, out_scale); // [RULE20]
   wire [DW-1:0] fx_q = shl_sat(FILT_Q, out_scale); // [RULE20]
   wire [DW-1:0] fl_i = shl_sat(FILT_I, exp_i); // [RULE17]
   wire [DW-1:0] fl_q = shl_sat(FILT_Q, exp_q); // [RULE17]
   wire [15:0] word_i = is_fixed ? fx_i[DW-1 -: 16]
                      : is_f12 ? {fl_i[DW-1 -: 12], exp_i}
                               : {4'h0, fl_i[DW-1 -: 8], exp_i}; // [RULE18]
   wire [15:0] word_q = is_fixed ? fx_q[DW-1 -: 16]
                      : is_f12 ? {fl_q[DW-1 -: 12], exp_q}
                               : {4'h0, fl_q[DW-1 -: 8], exp_q}; // [RULE18]

   // Output words, one cycle after the filter sample
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         OUT_I <= 16'h0000;
         OUT_Q <= 16'h0000;
         OUT_VALID <= 1'b0;
      end
      else
      begin
         OUT_VALID <= FILT_VALID && !bypass;
         if (FILT_VALID)
         begin
            OUT_I <= word_i;
            OUT_Q <= word_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Self-test registers
   // ----------------------------------------------------------------
   // Bypass takes the top 16 bits of the own fifth-order output
   wire st_v = bypass ? own_v : FILT_VALID; // [RULE13]
   wire [15:0] st_di = bypass ? own_i[DW-1 -: 16] : word_i; // [RULE13] [RULE21]
   wire [15:0] st_dq = bypass ? own_q[DW-1 -: 16] : word_q;
   // Rotate-and-xor signature; weak but cheap, enough to catch a stuck path
   wire [15:0] sig_i = {st_i_q[14:0], st_i_q[15]} ^ st_di; // [RULE22]
   wire [15:0] sig_q = {st_q_q[14:0], st_q_q[15]} ^ st_dq; // [RULE22]

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st_i_q <= 16'h0000;
         st_q_q <= 16'h0000;
      end
      else if (st_v)
      begin
         st_i_q <= MAP_TO_REGS ? st_di : sig_i; // [RULE21] [RULE22]
         st_q_q <= MAP_TO_REGS ? st_dq : sig_q; // [RULE21] [RULE22]
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_rs_dec_plus1: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
      ##1 RS_DECIMATION == {1'b0, $past(rs_dec_q)} + 13'h0001)
      else $error("resampler decimation not value plus one");
   a_interp_plus1: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
      WR && ADDR == cfc_pkg::ADDR_RS_INTERP
      |-> ##2 RS_INTERPOLATION == {1'b0, $past(WDATA[8:0], 2)} + 10'h001)
      else $error("resampler interpolation not value plus one");
   a_scale_by_level: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
      ##1 RS_SCALE == ($past(LEVEL_IND) ? $past(rs_scale_q[9:5]) : $past(rs_scale_q[4:0])))
      else $error("resampler scale not chosen by level pin");
   a_ptr_shadow_hold: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
      !FILT_START |=> $stable(CF_POINTER))
      else $error("coefficient pointer moved without a filter start");
   a_ptr_shadow_load: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
      FILT_START |=> CF_POINTER == $past(cf_ptr_q) && CF_PHASE_SEL == $past(cf_phase_q))
      else $error("shadows not loaded at filter start");
   a_coef_bank_addr: assert property (@(posedge CLK) disable iff (RST) // [RULE15]
      WR && ADDR[7] == 1'b0 |=> COEF_WE && COEF_ADDR[7] == $past(cf_ctrl_q[8]))
      else $error("coefficient write missed the selected bank");
   a_cross_partner: assert property (@(posedge CLK) disable iff (RST) // [RULE14]
      in_other |=> CF_IN_I == $past(CIC_I_ALL[PARTNER*DW +: DW]))
      else $error("cross-connect took the wrong channel");
   a_fixed_on_agc: assert property (@(posedge CLK) disable iff (RST) // [RULE19]
      FILT_VALID && AGC_ROUTE |=> OUT_I == $past(fx_i[DW-1 -: 16]))
      else $error("gain-loop data not in fixed point");
   a_map_loads_out: assert property (@(posedge CLK) disable iff (RST) // [RULE21]
      FILT_VALID && MAP_TO_REGS && !bypass |=> st_i_q == OUT_I)
      else $error("mapped self-test register not equal to output");
   a_bypass_stalls: assert property (@(posedge CLK) disable iff (RST) // [RULE13]
      bypass [*2] |-> !CF_IN_VALID && !OUT_VALID)
      else $error("filter path active while bypassed");
endmodule : cfc_channel_cfg
`default_nettype wire

// >>> verif/cfc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Host processor on the channel register port
// ----------------------------------------------------------------
module cfc_host_model (
   input wire logic CLK,
   output logic [7:0] ADDR,
   output logic [15:0] WDATA,
   output logic WR,
   output logic RD,
   input wire logic [15:0] RDATA
);
   // Bus starts idle
   initial
   begin
      ADDR = 8'h00;
      WDATA = 16'h0000;
      WR = 1'b0;
      RD = 1'b0;
   end
   // Data is scrambled after the strobe so a stale word never looks valid
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      ADDR = a;
      WDATA = v;
      WR = 1'b1;
      @(posedge CLK);
      #1;
      WR = 1'b0;
      WDATA = ~v;
      @(posedge CLK);
      #1;
   endtask : wr
   // Read word is taken one edge after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      ADDR = a;
      RD = 1'b1;
      @(posedge CLK);
      #1;
      RD = 1'b0;
      @(posedge CLK);
      #1;
      v = RDATA;
   endtask : rd
   // Decimation must exceed interpolation, else no usable scale exists
   task automatic set_resampler(input logic [11:0] dm1, input logic [8:0] lm1);
      if (dm1 > {3'h0, lm1})
      begin
         wr(8'h90, {4'h0, dm1});
         wr(8'h91, {7'h0, lm1});
      end
   endtask : set_resampler
   // Reserved places only ever see zeros
   task automatic clear_reserved();
      wr(8'h93, 16'h0000);
      wr(8'h96, 16'h0000);
   endtask : clear_reserved
endmodule : cfc_host_model
`default_nettype wire

// >>> verif/cfc_channel_cfg_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Channel configuration bench
// ----------------------------------------------------------------
module cfc_channel_cfg_tb_top;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] ADDR, COEF_ADDR, CF_PHASE_SEL, CF_POINTER, CIC_VALID_ALL, cw_addr;
   logic [15:0] WDATA, RDATA, COEF_WDATA, OUT_I, OUT_Q, rd_val;
   logic WR, RD, COEF_WE, LEVEL_IND, EXP_INVERT, EXP_WEIGHT_HI, FILT_START;
   logic CF_IN_VALID, FILT_VALID, AGC_ROUTE, MAP_TO_REGS, OUT_VALID;
   logic [4:0] RS_SCALE, FO_SCALE;
   logic [12:0] RS_DECIMATION;
   logic [9:0] RS_INTERPOLATION;
   logic [8:0] FO_DECIMATION, CF_DECIMATION, CF_TAP_COUNT;
   logic [191:0] CIC_I_ALL, CIC_Q_ALL;
   logic [23:0] CF_IN_I, CF_IN_Q, FILT_I, FILT_Q;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int cw_cnt = 0;

   // Channel 2 so the cross-connect is not simply its mirror partner
   cfc_channel_cfg #(.CHANNEL(2), .DW(24)) uut (
      .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .COEF_WE(COEF_WE), .COEF_ADDR(COEF_ADDR), .COEF_WDATA(COEF_WDATA),
      .LEVEL_IND(LEVEL_IND), .EXP_INVERT(EXP_INVERT), .EXP_WEIGHT_HI(EXP_WEIGHT_HI),
      .RS_SCALE(RS_SCALE), .RS_DECIMATION(RS_DECIMATION),
      .RS_INTERPOLATION(RS_INTERPOLATION), .FO_DECIMATION(FO_DECIMATION),
      .FO_SCALE(FO_SCALE),
      .CF_DECIMATION(CF_DECIMATION), .CF_TAP_COUNT(CF_TAP_COUNT), .FILT_START(FILT_START),
      .CF_PHASE_SEL(CF_PHASE_SEL), .CF_POINTER(CF_POINTER), .CIC_I_ALL(CIC_I_ALL),
      .CIC_Q_ALL(CIC_Q_ALL), .CIC_VALID_ALL(CIC_VALID_ALL), .CF_IN_I(CF_IN_I),
      .CF_IN_Q(CF_IN_Q), .CF_IN_VALID(CF_IN_VALID), .FILT_I(FILT_I), .FILT_Q(FILT_Q),
      .FILT_VALID(FILT_VALID), .AGC_ROUTE(AGC_ROUTE), .MAP_TO_REGS(MAP_TO_REGS),
      .OUT_I(OUT_I), .OUT_Q(OUT_Q), .OUT_VALID(OUT_VALID)
   );
   cfc_host_model host (
      .CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA)
   );

   always #5 CLK = ~CLK;
   // Coefficient pulses last one cycle, so they are caught here; also the hang limit
   always @(posedge CLK)
   begin
      cycles <= cycles + 1;
      if (COEF_WE === 1'b1)
      begin
         cw_cnt <= cw_cnt + 1;
         cw_addr <= COEF_ADDR;
      end
      if (cycles == 3000)
      begin
         err_count = err_count + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : tick
   task automatic put(input logic [7:0] a, input logic [15:0] v);
      host.wr(a, v);
      tick(1);
   endtask : put
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      host.rd(a, rd_val);
      chk(24'(rd_val), 24'(e));
   endtask : rdchk
   // Formatted words appear one edge after the filter result
   task automatic filt(input logic [23:0] i, input logic [23:0] q, input logic [15:0] ei,
                       input logic [15:0] eq, input logic v);
      FILT_I = i;
      FILT_Q = q;
      FILT_VALID = 1'b1;
      tick(1);
      FILT_VALID = 1'b0;
      chk(24'(OUT_VALID), 24'(v));
      if (v)
      begin
         chk(24'(OUT_I), 24'(ei));
         chk(24'(OUT_Q), 24'(eq));
      end
      tick(1);
   endtask : filt
   task automatic cic(input logic [23:0] ei, input logic [23:0] eq);
      CIC_VALID_ALL = 8'h06;
      tick(1);
      CIC_VALID_ALL = 8'h00;
      chk(24'(CF_IN_VALID), 24'h1);
      chk(CF_IN_I, ei);
      chk(CF_IN_Q, eq);
      tick(1);
   endtask : cic
   task automatic start();
      FILT_START = 1'b1;
      tick(1);
      FILT_START = 1'b0;
      tick(1);
   endtask : start

   // Main sequence
   initial
   begin
      LEVEL_IND = 1'b0;
      FILT_START = 1'b0;
      CIC_I_ALL = 192'h0;
      CIC_Q_ALL = 192'h0;
      CIC_VALID_ALL = 8'h00;
      FILT_I = 24'h000000;
      FILT_Q = 24'h000000;
      FILT_VALID = 1'b0;
      AGC_ROUTE = 1'b0;
      MAP_TO_REGS = 1'b1;
      tick(4);
      RST = 1'b0;
      chk(24'(RS_DECIMATION), 24'h1);
      chk(24'(CF_TAP_COUNT), 24'h1);
      host.set_resampler(12'hfff, 9'h1ff);
      tick(2);
      chk(24'(RS_DECIMATION), 24'h1000);
      chk(24'(RS_INTERPOLATION), 24'h200);
      rdchk(8'h90, 16'h0fff);
      rdchk(8'h91, 16'h01ff);
      host.set_resampler(12'h001, 9'h000);
      tick(2);
      chk(24'(RS_DECIMATION), 24'h2);
      chk(24'(RS_INTERPOLATION), 24'h1);
      LEVEL_IND = 1'b1;
      put(8'h92, 16'h0d45);
      chk(24'({EXP_INVERT, EXP_WEIGHT_HI, RS_SCALE}), 24'h6a);
      LEVEL_IND = 1'b0;
      tick(2);
      chk(24'(RS_SCALE), 24'h05);
      put(8'h92, 16'h0400);
      chk(24'({EXP_INVERT, EXP_WEIGHT_HI}), 24'h1);
      host.clear_reserved();
      put(8'h97, 16'hffff);
      put(8'ha5, 16'hffff);
      rdchk(8'h93, 16'h0000);
      rdchk(8'h97, 16'h0000);
      rdchk(8'ha5, 16'h0000);
      // Fifth-order scale is a plain copy, seen on the port and on read-back
      put(8'h95, 16'h0013);
      chk(24'(FO_SCALE), 24'h13);
      rdchk(8'h95, 16'h0013);
      put(8'h94, 16'h00ff);
      put(8'ha0, 16'h00ff);
      put(8'ha2, 16'h0007);
      chk(24'(FO_DECIMATION), 24'h100);
      chk(24'(CF_DECIMATION), 24'h100);
      chk(24'(CF_TAP_COUNT), 24'h8);
      // Shadows move only at a filter start
      put(8'ha1, 16'h0033);
      put(8'ha3, 16'h0044);
      chk(24'({CF_PHASE_SEL, CF_POINTER}), 24'h0);
      start();
      chk(24'({CF_PHASE_SEL, CF_POINTER}), 24'h3344);
      put(8'ha1, 16'h0055);
      put(8'ha3, 16'h0066);
      chk(24'({CF_PHASE_SEL, CF_POINTER}), 24'h3344);
      start();
      chk(24'({CF_PHASE_SEL, CF_POINTER}), 24'h5566);
      // Bank bit steers host coefficient writes
      put(8'ha4, 16'h0100);
      host.wr(8'h05, 16'hbeef);
      chk(24'(cw_addr), 24'h85);
      put(8'ha4, 16'h0000);
      host.wr(8'h7f, 16'h1234);
      chk({cw_addr, COEF_WDATA}, 24'h7f1234);
      chk(24'(cw_cnt), 24'h2);
      CIC_I_ALL[47:24] = 24'h111111;
      CIC_I_ALL[71:48] = 24'h222222;
      CIC_Q_ALL[47:24] = 24'h0a0a0a;
      CIC_Q_ALL[71:48] = 24'h0b0b0b;
      cic(24'h222222, 24'h0b0b0b);
      put(8'ha4, 16'h0200);
      cic(24'h111111, 24'h0a0a0a);
      // Self-test register in both modes, then the output formats
      put(8'ha4, 16'h0004);
      filt(24'h000123, 24'hfffedd, 16'h0012, 16'hffed, 1'b1);
      rdchk(8'ha5, 16'h0012);
      rdchk(8'ha6, 16'hffed);
      MAP_TO_REGS = 1'b0;
      filt(24'h000123, 24'hfffedd, 16'h0012, 16'hffed, 1'b1);
      rdchk(8'ha5, 16'h0036);
      rdchk(8'ha6, 16'h0036);
      MAP_TO_REGS = 1'b1;
      put(8'ha4, 16'h0001);
      filt(24'h400000, 24'ha00000, 16'h7fff, 16'h8000, 1'b1);
      put(8'ha4, 16'h0020);
      filt(24'h000123, 24'h100000, 16'h48ce, 16'h4002, 1'b1);
      put(8'ha4, 16'h0030);
      filt(24'h000123, 24'h100000, 16'h48ce, 16'h4002, 1'b1);
      put(8'ha4, 16'h00a0);
      filt(24'h000123, 24'h100000, 16'h0002, 16'h4002, 1'b1);
      put(8'ha4, 16'h0010);
      filt(24'h000123, 24'h100000, 16'h048e, 16'h0402, 1'b1);
      put(8'ha4, 16'h0063);
      filt(24'h000123, 24'h100000, 16'h0003, 16'h7ff3, 1'b1);
      AGC_ROUTE = 1'b1;
      put(8'ha4, 16'h0024);
      filt(24'h000123, 24'h100000, 16'h0012, 16'h7fff, 1'b1);
      AGC_ROUTE = 1'b0;
      // Bypass sends own fifth-order data to the self-test registers
      put(8'ha4, 16'h0400);
      CIC_I_ALL[71:48] = 24'habcdef;
      CIC_Q_ALL[71:48] = 24'h123456;
      CIC_VALID_ALL = 8'h04;
      tick(1);
      CIC_VALID_ALL = 8'h00;
      chk(24'(CF_IN_VALID), 24'h0);
      rdchk(8'ha5, 16'habcd);
      rdchk(8'ha6, 16'h1234);
      filt(24'h000123, 24'h100000, 16'h0000, 16'h0000, 1'b0);
      conclude();
   end
endmodule : cfc_channel_cfg_tb_top
`default_nettype wire
